/* File: inc/lrb_regs.svh */
// Purpose: Offsets, field positions, reset values and timing counts of the regulator bank.
// Assumes: Byte-wide registers, one byte address each.
// Notes: Cycle counts are derived from the clock rate in kHz.
`ifndef LRB_REGS_SVH
`define LRB_REGS_SVH

// Register offsets.
`define LRB_OFS_A_VCODE 8'h54
`define LRB_OFS_A_CTRL  8'h55
`define LRB_OFS_B_VCODE 8'h60
`define LRB_OFS_B_CTRL  8'h61
`define LRB_OFS_C_VCODE 8'h64
`define LRB_OFS_C_CTRL  8'h65
`define LRB_OFS_IRQ_ST  8'h70
`define LRB_OFS_IRQ_MSK 8'h71

// Control byte and voltage code field positions.
`define LRB_BIT_ON      7
`define LRB_BIT_DSCH    6
`define LRB_BIT_LOWQ    5
`define LRB_BIT_DLY_HI  4
`define LRB_BIT_DLY_LO  2
`define LRB_BIT_ALLOW   1
`define LRB_BIT_OK      0
`define LRB_BIT_VC_HI   5

// Reset values.
`define LRB_RST_VCODE   6'h00
`define LRB_RST_CTRL    7'h00
`define LRB_RST_MASK    3'h0

// Timing: clock rate, reset output delay and turn-on delay step.
`define LRB_CLK_KHZ     40000
`define LRB_RST_DLY_MS  260
`define LRB_RST_DLY_CYC (`LRB_RST_DLY_MS * `LRB_CLK_KHZ)
`define LRB_TON_STEP_MS 1
`define LRB_TON_STEP_CYC (`LRB_TON_STEP_MS * `LRB_CLK_KHZ)
`define LRB_TMR_W       24

`endif

/* File: inc/lrb_pkg.sv */
// Purpose: Types shared by the regulator bank modules.
// Assumes: The register header is on the include path.
// Notes: The configuration struct carries one regulator's writable fields.
`include "lrb_regs.svh"
package lrb_pkg;
	typedef logic [7:0] lrb_byte_t;
	typedef logic [`LRB_TMR_W-1:0] lrb_tmr_t;
	typedef struct packed {
		logic       on;
		logic       discharge;
		logic       low_quiescent_mode;
		logic [2:0] delay;
		logic       fault_irq_allow;
		logic [5:0] voltage_code;
	} lrb_ldo_cfg_s;
endpackage

/* File: hw/lrb_sync.sv */
// Purpose: Two-stage synchroniser for pin inputs.
// Assumes: Inputs are levels from outside the clock domain.
// Notes: The first stage feeds only the second.
module lrb_sync #(
	parameter int             W    = 4,
	parameter logic [W-1:0]   RSTV = '0
) (
	// Clock, reset and enable.
	input  wire logic         clk,
	input  wire logic         nrst,
	input  wire logic         ce,
	// Data.
	input  wire logic [W-1:0] d,
	output logic      [W-1:0] q
);
	logic [W-1:0] meta_ff;
	logic [W-1:0] q_ff;

	// Both stages shift only while the clock enable is high.
	always_ff @(posedge clk) begin
		if (!nrst) begin
			meta_ff <= RSTV;
			q_ff <= RSTV;
		end else if (ce) begin
			meta_ff <= d;
			q_ff <= meta_ff;
		end
	end

	assign q = q_ff;
endmodule

/* File: hw/lrb_timer.sv */
// Purpose: Down counter that signals when a run has lasted a loaded count.
// Assumes: The load value is stable while run is high.
// Notes: Done rises load plus one enabled edges after run is first seen high.
module lrb_timer
	import lrb_pkg::*;
(
	// Clock, reset and enable.
	input  wire logic     clk,
	input  wire logic     nrst,
	input  wire logic     ce,
	// Control.
	input  wire logic     run,
	input  wire lrb_tmr_t load,
	output logic          done
);
	lrb_tmr_t cnt_ff;
	logic     armed_ff;
	logic     done_ff;

	// Disarm while idle, capture the load at the first running edge, count down, then hold done.
	always_ff @(posedge clk) begin
		if (!nrst) begin
			cnt_ff <= '0;
			armed_ff <= 1'b0;
			done_ff <= 1'b0;
		end else if (ce) begin
			if (!run) begin
				cnt_ff <= load;
				armed_ff <= 1'b0;
				done_ff <= 1'b0;
			end else if (!armed_ff) begin
				cnt_ff <= load; // A load written together with the start is honoured.
				armed_ff <= 1'b1;
			end else if (cnt_ff != '0) begin
				cnt_ff <= cnt_ff - 1'b1;
			end else begin
				done_ff <= 1'b1;
			end
		end
	end

	assign done = done_ff;
endmodule

/* File: hw/lrb_top.sv */
// Purpose: Control and status registers for three low-dropout regulators.
// Assumes: CLOCK stands for the internal oscillator; pins are synchronised here.
// Notes: Open-drain pins are split into a constant low value and an enable.
`include "lrb_regs.svh"
module lrb_top
	import lrb_pkg::*;
#(
	parameter int unsigned RST_DLY_CYC  = `LRB_RST_DLY_CYC,
	parameter int unsigned TON_STEP_CYC = `LRB_TON_STEP_CYC
) (
	// Clock, reset and clock enable.
	input  wire logic               CLOCK,
	input  wire logic               NRST,
	input  wire logic               CE,
	// Register port.
	input  wire logic [7:0]         ADDR,
	input  wire logic [7:0]         WDATA,
	input  wire logic               WR,
	input  wire logic               RD,
	output logic      [7:0]         RDATA,
	// Analog and pin inputs.
	input  wire logic [2:0]         PWR_OK,
	input  wire logic               BUTTON_IN_N,
	// Regulator controls.
	output lrb_ldo_cfg_s [2:0]      LDO_CFG,
	output logic      [2:0]         LDO_RUN,
	output logic      [2:0]         LDO_DISCHARGE,
	// Open-drain outputs.
	output logic                    INTERRUPT_OUT_N_O,
	output logic                    INTERRUPT_OUT_N_OE,
	output logic                    RESET_OUT_N_O,
	output logic                    RESET_OUT_N_OE,
	output logic                    BUTTON_STATUS_OUT_N_O,
	output logic                    BUTTON_STATUS_OUT_N_OE
);
	// One-hot regulator select for one of three offsets.
	function automatic logic [2:0] sel3(input logic [7:0] a, input logic [7:0] oa,
		input logic [7:0] ob, input logic [7:0] oc);
		sel3 = {a == oc, a == ob, a == oa};
	endfunction

	// Control byte as read back, with the live power-good flag in bit 0.
	function automatic lrb_byte_t ctrl_byte(input lrb_ldo_cfg_s c, input logic ok);
		ctrl_byte = {c.on, c.discharge, c.low_quiescent_mode, c.delay,
			c.fault_irq_allow, ok};
	endfunction

	// Turn-on wait in cycles for a delay code.
	function automatic lrb_tmr_t ton_load(input logic [2:0] code);
		ton_load = lrb_tmr_t'(code * TON_STEP_CYC);
	endfunction

	lrb_ldo_cfg_s [2:0] cfg_ff;
	lrb_ldo_cfg_s [2:0] nxt_cfg;
	logic      [2:0]    run_ff;
	logic      [2:0]    nxt_run;
	logic      [2:0]    dsch_ff;
	logic      [2:0]    pg_prev_ff;
	logic      [2:0]    stat_ff;
	logic      [2:0]    nxt_stat;
	logic      [2:0]    mask_ff;
	logic      [2:0]    nxt_mask;
	lrb_byte_t          rdata_ff;
	lrb_byte_t          rd_val;
	logic               rst_oe_ff;
	logic               btn_oe_ff;
	logic      [2:0]    pg_sync;
	logic               btn_sync;
	logic      [2:0]    ton_done;
	logic               rst_done;
	logic      [2:0]    on_vec;
	logic      [2:0]    allow_vec;
	logic      [2:0]    fault_evt;
	lrb_tmr_t           ok_cnt_ff;

	// Power-good comparators and the button pin cross into the clock domain.
	lrb_sync #(
		.W    (4),
		.RSTV (4'h8)
	) u_sync (
		.clk  (CLOCK),
		.nrst (NRST),
		.ce   (CE),
		.d    ({BUTTON_IN_N, PWR_OK}),
		.q    ({btn_sync, pg_sync})
	);

	// Address decode for the register port.
	wire [2:0] hit_vcode = sel3(ADDR, `LRB_OFS_A_VCODE, `LRB_OFS_B_VCODE, `LRB_OFS_C_VCODE);
	wire [2:0] hit_ctrl  = sel3(ADDR, `LRB_OFS_A_CTRL, `LRB_OFS_B_CTRL, `LRB_OFS_C_CTRL);
	wire       hit_stat  = (ADDR == `LRB_OFS_IRQ_ST);
	wire       hit_mask  = (ADDR == `LRB_OFS_IRQ_MSK);
	wire [2:0] wr_vcode  = {3{WR}} & hit_vcode;
	wire [2:0] wr_ctrl   = {3{WR}} & hit_ctrl;
	wire [2:0] stat_clr  = (WR && hit_stat) ? WDATA[2:0] : 3'h0;

	// Next register values on writes; bit 0 of a control write is dropped.
	always_comb begin
		nxt_cfg = cfg_ff;
		for (int i = 0; i < 3; i++) begin
			if (wr_vcode[i]) begin
				nxt_cfg[i].voltage_code = WDATA[`LRB_BIT_VC_HI:0];
			end
			if (wr_ctrl[i]) begin
				nxt_cfg[i].on = WDATA[`LRB_BIT_ON];
				nxt_cfg[i].discharge = WDATA[`LRB_BIT_DSCH];
				nxt_cfg[i].low_quiescent_mode = WDATA[`LRB_BIT_LOWQ];
				nxt_cfg[i].delay = WDATA[`LRB_BIT_DLY_HI:`LRB_BIT_DLY_LO];
				nxt_cfg[i].fault_irq_allow = WDATA[`LRB_BIT_ALLOW];
			end
		end
	end

	// Field vectors used by the sequencing and interrupt logic.
	always_comb begin
		for (int i = 0; i < 3; i++) begin
			on_vec[i] = cfg_ff[i].on;
			allow_vec[i] = cfg_ff[i].fault_irq_allow;
		end
	end

	// Turn-on wait per regulator, reloaded whenever the enable is low.
	for (genvar g = 0; g < 3; g++) begin : g_ton
		lrb_timer u_ton (
			.clk  (CLOCK),
			.nrst (NRST),
			.ce   (CE),
			.run  (on_vec[g]),
			.load (ton_load(cfg_ff[g].delay)),
			.done (ton_done[g])
		);
	end

	// A regulator runs once enabled and its wait has elapsed.
	assign nxt_run = on_vec & ton_done;

	// A running regulator whose power good falls is a fault; set beats clear.
	assign fault_evt = run_ff & pg_prev_ff & ~pg_sync;
	assign nxt_stat = fault_evt | (stat_ff & ~stat_clr);
	assign nxt_mask = (WR && hit_mask) ? WDATA[2:0] : mask_ff;

	// Reset output waits until every enabled regulator is good for the delay.
	wire all_ok = &(pg_sync | ~on_vec);

	lrb_timer u_rst (
		.clk  (CLOCK),
		.nrst (NRST),
		.ce   (CE),
		.run  (all_ok),
		.load (lrb_tmr_t'(RST_DLY_CYC - 1)),
		.done (rst_done)
	);

	// Read data; unmapped and reserved bits read as zero.
	always_comb begin
		rd_val = 8'h00;
		for (int i = 0; i < 3; i++) begin
			if (hit_vcode[i]) begin
				rd_val = {2'h0, cfg_ff[i].voltage_code};
			end
			if (hit_ctrl[i]) begin
				rd_val = ctrl_byte(cfg_ff[i], pg_sync[i]);
			end
		end
		if (hit_stat) begin
			rd_val = {5'h00, stat_ff};
		end
		if (hit_mask) begin
			rd_val = {5'h00, mask_ff};
		end
	end

	// Register state; everything holds while the clock enable is low.
	always_ff @(posedge CLOCK) begin
		if (!NRST) begin
			for (int i = 0; i < 3; i++) begin
				cfg_ff[i] <= {`LRB_RST_CTRL, `LRB_RST_VCODE};
			end
			mask_ff <= `LRB_RST_MASK;
			stat_ff <= 3'h0;
			rdata_ff <= 8'h00;
		end else if (CE) begin
			cfg_ff <= nxt_cfg;
			mask_ff <= nxt_mask;
			stat_ff <= nxt_stat;
			rdata_ff <= RD ? rd_val : 8'h00;
		end
	end

	// Regulator drive state and discharge while shut down.
	always_ff @(posedge CLOCK) begin
		if (!NRST) begin
			run_ff <= 3'h0;
			dsch_ff <= 3'h0;
			pg_prev_ff <= 3'h0;
		end else if (CE) begin
			run_ff <= nxt_run;
			for (int i = 0; i < 3; i++) begin
				dsch_ff[i] <= cfg_ff[i].discharge & ~nxt_run[i];
			end
			pg_prev_ff <= pg_sync;
		end
	end

	// Open-drain enables for reset and button status.
	always_ff @(posedge CLOCK) begin
		if (!NRST) begin
			rst_oe_ff <= 1'b1;
			btn_oe_ff <= 1'b0;
		end else if (CE) begin
			rst_oe_ff <= ~rst_done;
			btn_oe_ff <= ~btn_sync;
		end
	end

	// Outputs; open-drain pins never drive high.
	assign RDATA = rdata_ff;
	assign LDO_CFG = cfg_ff;
	assign LDO_RUN = run_ff;
	assign LDO_DISCHARGE = dsch_ff;
	assign INTERRUPT_OUT_N_O = 1'b0;
	assign RESET_OUT_N_O = 1'b0;
	assign BUTTON_STATUS_OUT_N_O = 1'b0;
	assign INTERRUPT_OUT_N_OE = |(stat_ff & mask_ff & allow_vec);
	assign RESET_OUT_N_OE = rst_oe_ff;
	assign BUTTON_STATUS_OUT_N_OE = btn_oe_ff;

	// Helper: enabled cycles for which all enabled regulators were good.
	always_ff @(posedge CLOCK) begin
		if (!NRST) begin
			ok_cnt_ff <= '0;
		end else if (CE) begin
			if (!all_ok) begin
				ok_cnt_ff <= '0;
			end else if (ok_cnt_ff != '1) begin
				ok_cnt_ff <= ok_cnt_ff + 1'b1;
			end
		end
	end

	// Checks on the register and sequencing behaviour.
	default clocking cb @(posedge CLOCK);
	endclocking
	default disable iff (!NRST);

	sequence off_hold;
		!LDO_RUN[0] [*3];
	endsequence

	sequence bad_then_tick;
		CE && !all_ok ##1 CE;
	endsequence

	vcode_read_a: assert property (
		CE && RD && hit_vcode[0] |=> RDATA == {2'h0, cfg_ff[0].voltage_code})
		else $error("voltage code read back wrong");

	rsvd_zero_a: assert property (
		CE && RD && (|hit_vcode) |=> RDATA[7:6] == 2'h0)
		else $error("reserved voltage bits not zero");

	ctrl_write_a: assert property (
		CE && WR && hit_ctrl[1] |=> ctrl_byte(cfg_ff[1], 1'b0) == {$past(WDATA[7:1]), 1'b0})
		else $error("control write not stored");

	ok_readonly_a: assert property (
		CE && RD && hit_ctrl[2] |=> RDATA[0] == $past(pg_sync[2]))
		else $error("power good bit does not follow input");

	run_off_a: assert property (
		CE && !cfg_ff[0].on |=> !LDO_RUN[0])
		else $error("regulator runs while disabled");

	turn_on_wait_a: assert property (
		CE && $rose(cfg_ff[0].on) && cfg_ff[0].delay != 3'h0 |-> off_hold)
		else $error("turn-on delay skipped");

	discharge_on_a: assert property (
		CE && cfg_ff[0].discharge && !cfg_ff[0].on |=> LDO_DISCHARGE[0] && !LDO_RUN[0])
		else $error("discharge not engaged in shutdown");

	open_drain_a: assert property (
		!INTERRUPT_OUT_N_O && !RESET_OUT_N_O && !BUTTON_STATUS_OUT_N_O)
		else $error("open-drain output driven high");

	fault_set_a: assert property (
		CE && fault_evt[0] |=> stat_ff[0] && (mask_ff[0] && allow_vec[0] -> INTERRUPT_OUT_N_OE))
		else $error("fault lost or interrupt not raised");

	irq_hold_a: assert property (
		stat_ff[0] && mask_ff[0] && allow_vec[0] && !WR |=> INTERRUPT_OUT_N_OE)
		else $error("interrupt released before service");

	reset_hold_a: assert property (
		bad_then_tick |=> RESET_OUT_N_OE)
		else $error("reset output released while supply bad");

	reset_len_a: assert property (
		$fell(RESET_OUT_N_OE) |-> ok_cnt_ff > RST_DLY_CYC)
		else $error("reset output released too early");

	// Checks on read data idling, status service, mask and voltage code writes, pins and the clock enable.
	rdata_idle_a: assert property (
		CE && !RD |=> RDATA == 8'h00)
		else $error("read data not zero outside a read");

	stat_clear_a: assert property (
		CE && WR && hit_stat && WDATA[0] && !fault_evt[0] |=> !stat_ff[0])
		else $error("status bit not cleared by a one");

	stat_keep_a: assert property (
		CE && stat_ff[0] && !(WR && hit_stat && WDATA[0]) |=> stat_ff[0])
		else $error("status bit lost without service");

	mask_write_a: assert property (
		CE && WR && hit_mask |=> mask_ff == $past(WDATA[2:0]))
		else $error("mask write not stored");

	vcode_write_a: assert property (
		CE && WR && hit_vcode[2] |=> cfg_ff[2].voltage_code == $past(WDATA[5:0]))
		else $error("voltage code write not stored");

	discharge_off_a: assert property (
		CE && !cfg_ff[0].discharge |=> !LDO_DISCHARGE[0])
		else $error("discharge engaged while not allowed");

	button_pull_a: assert property (
		CE && !btn_sync |=> BUTTON_STATUS_OUT_N_OE)
		else $error("button status not pulled low");

	freeze_hold_a: assert property (
		!CE |=> $stable(cfg_ff) && $stable(stat_ff) && $stable(RDATA))
		else $error("state changed while clock enable low");
endmodule

/* File: sim/lrb_ldo_model.sv */
// Purpose: Behavioural model of the three regulators behind the bank.
// Assumes: Power good follows the run command through a short ramp.
// Notes: A slow part reports power good eight cycles late, a fast one a cycle late.
module lrb_ldo_model (
	// Clock.
	input  wire logic       clk,
	// Regulator commands and faults ordered by the bench.
	input  wire logic [2:0] run,
	input  wire logic [2:0] drop,
	input  wire logic       slow,
	// Power-good comparators.
	output logic      [2:0] pwr_ok
);
	timeunit 1ns;
	timeprecision 1ps;

	logic [7:0] ramp_ff [3];

	// Each output ramps up after its regulator runs and collapses on a fault.
	always_ff @(posedge clk) begin
		for (int i = 0; i < 3; i++) begin
			ramp_ff[i] <= {ramp_ff[i][6:0], run[i] & ~drop[i]};
		end
	end

	// The comparator reports from the fast or the slow end of the ramp.
	always_comb begin
		for (int i = 0; i < 3; i++) begin
			pwr_ok[i] = slow ? ramp_ff[i][7] : ramp_ff[i][0];
		end
	end
endmodule

/* File: sim/lrb_top_test.sv */
// Purpose: Self-checking bench of the regulator register bank.
// Assumes: Short delay parameters so that the run stays brief.
// Notes: Counts are reckoned from the edge at which a request is taken.
`include "lrb_regs.svh"
module lrb_top_test;
	timeunit 1ns;
	timeprecision 1ps;

	localparam int RST_CYC = 20;
	localparam int STEP    = 4;
	localparam logic [7:0] VOFS [3] = '{`LRB_OFS_A_VCODE, `LRB_OFS_B_VCODE, `LRB_OFS_C_VCODE};
	localparam logic [7:0] COFS [3] = '{`LRB_OFS_A_CTRL, `LRB_OFS_B_CTRL, `LRB_OFS_C_CTRL};

	logic                         clk = 1'b0;
	logic                         nrst = 1'b0;
	logic                         ce = 1'b1;
	logic [7:0]                   addr = 8'h00;
	logic [7:0]                   wdata = 8'h00;
	logic                         wr = 1'b0;
	logic                         rd = 1'b0;
	logic [7:0]                   rdata;
	logic [2:0]                   pwr_ok;
	logic                         button_n = 1'b1;
	lrb_pkg::lrb_ldo_cfg_s [2:0]  ldo_cfg;
	logic [2:0]                   ldo_run;
	logic [2:0]                   ldo_dsch;
	logic                         irq_o, irq_oe, rst_o, rst_oe, btn_o, btn_oe;
	logic [2:0]                   drop = 3'h0;
	logic                         slow = 1'b0;
	int                           bad_count = 0;
	int                           cmp_count = 0;
	int                           cycles = 0;

	// Clock at 40 MHz.
	always #12.5 clk = ~clk;

	lrb_top #(.RST_DLY_CYC(RST_CYC), .TON_STEP_CYC(STEP)) dut (
		.CLOCK(clk), .NRST(nrst), .CE(ce), .ADDR(addr), .WDATA(wdata), .WR(wr), .RD(rd),
		.RDATA(rdata), .PWR_OK(pwr_ok), .BUTTON_IN_N(button_n), .LDO_CFG(ldo_cfg),
		.LDO_RUN(ldo_run), .LDO_DISCHARGE(ldo_dsch), .INTERRUPT_OUT_N_O(irq_o),
		.INTERRUPT_OUT_N_OE(irq_oe), .RESET_OUT_N_O(rst_o), .RESET_OUT_N_OE(rst_oe),
		.BUTTON_STATUS_OUT_N_O(btn_o), .BUTTON_STATUS_OUT_N_OE(btn_oe)
	);

	lrb_ldo_model model (.clk(clk), .run(ldo_run), .drop(drop), .slow(slow), .pwr_ok(pwr_ok));

	// Prints the counts and the verdict, then ends the run.
	task automatic stop_test();
		$display("comparisons %0d mismatches %0d", cmp_count, bad_count);
		if (bad_count == 0 && cmp_count > 0) begin
			$display("ALL CHECKS OK");
		end else begin
			$display("CHECKS NOT OK");
		end
		$finish;
	endtask

	// Compares one value and reports a mismatch at once.
	task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
		cmp_count++;
		if (got !== exp) begin
			bad_count++;
			$display("ERROR %s expected %h seen %h", what, exp, got);
		end
	endtask

	// Waits n edges and lets their updates settle.
	task automatic tick(input int n);
		repeat (n) @(posedge clk);
		#1;
	endtask

	// One-cycle write strobe.
	task automatic reg_write(input logic [7:0] a, input logic [7:0] d);
		@(posedge clk);
		wr <= 1'b1;
		addr <= a;
		wdata <= d;
		@(posedge clk);
		wr <= 1'b0;
	endtask

	// One-cycle read strobe; the data stand in the following cycle.
	task automatic read_chk(input string what, input logic [7:0] a, input logic [7:0] exp);
		@(posedge clk);
		rd <= 1'b1;
		addr <= a;
		@(posedge clk);
		rd <= 1'b0;
		#1;
		chk(what, exp, rdata);
	endtask

	// Counts edges until the reset enable (which 0) or run of regulator a (which 1) is at a level.
	task automatic edges_until(input int which, input logic lvl, output int n);
		n = 0;
		while (((which == 0) ? rst_oe : ldo_run[0]) !== lvl && n < 100) begin
			@(posedge clk);
			#1;
			n++;
		end
	endtask

	// Reset values, idle open-drain pins and the timed reset release.
	task automatic t_reset();
		int n;
		#1;
		chk("reset pin held", 8'h01, {7'h0, rst_oe});
		chk("drain levels", 8'h00, {5'h0, irq_o, rst_o, btn_o});
		edges_until(0, 1'b0, n);
		chk("reset delay", 8'(RST_CYC + 2), 8'(n));
		for (int i = 0; i < 3; i++) begin
			read_chk("vcode reset", VOFS[i], 8'h00);
			read_chk("ctrl reset", COFS[i], 8'h00);
		end
		$display("test reset done");
	endtask

	// Field storage, reserved bits, read-only bit and unmapped space.
	task automatic t_fields();
		for (int i = 0; i < 3; i++) begin
			reg_write(VOFS[i], 8'hff);
			reg_write(COFS[i], 8'h7f);
			read_chk("vcode", VOFS[i], 8'h3f);
			read_chk("ctrl", COFS[i], 8'h7e);
			chk("vcode out", 8'h3f, {2'h0, ldo_cfg[i].voltage_code});
			chk("ctrl out", 8'h3f, {1'b0, ldo_cfg[i][12:6]});
			chk("discharge", 8'h01, {7'h0, ldo_dsch[i]});
			reg_write(COFS[i], 8'h00);
			tick(2);
			chk("no discharge", 8'h00, {7'h0, ldo_dsch[i]});
		end
		reg_write(8'h56, 8'hff);
		read_chk("unmapped", 8'h56, 8'h00);
		tick(1);
		chk("read data idle", 8'h00, rdata);
		$display("test fields done");
	endtask

	// Turn-on wait, power good readback and reset output sequencing.
	task automatic t_turnon();
		int n;
		slow <= 1'b1;
		reg_write(COFS[0], 8'h8e);
		edges_until(1, 1'b1, n);
		chk("turn-on wait", 8'(3 * STEP + 3), 8'(n));
		chk("reset while low", 8'h01, {7'h0, rst_oe});
		tick(12);
		read_chk("power good", COFS[0], 8'h8f);
		tick(RST_CYC + 4);
		chk("reset released", 8'h00, {7'h0, rst_oe});
		$display("test turnon done");
	endtask

	// Fault interrupt: raise, refuse a zero write, clear, suppress, shut down.
	task automatic t_irq();
		slow <= 1'b0;
		reg_write(`LRB_OFS_IRQ_MSK, 8'h01);
		drop <= 3'h1;
		tick(6);
		chk("irq raised", 8'h01, {7'h0, irq_oe});
		read_chk("status", `LRB_OFS_IRQ_ST, 8'h01);
		reg_write(`LRB_OFS_IRQ_ST, 8'h00);
		tick(1);
		chk("irq kept", 8'h01, {7'h0, irq_oe});
		drop <= 3'h0;
		tick(4);
		reg_write(`LRB_OFS_IRQ_ST, 8'h01);
		tick(1);
		chk("irq cleared", 8'h00, {7'h0, irq_oe});
		reg_write(COFS[0], 8'h8c);
		drop <= 3'h1;
		tick(6);
		chk("irq suppressed", 8'h00, {7'h0, irq_oe});
		read_chk("status set", `LRB_OFS_IRQ_ST, 8'h01);
		drop <= 3'h0;
		reg_write(COFS[0], 8'h40);
		tick(2);
		chk("shut down", 8'h01, {ldo_run[0], 6'h0, ldo_dsch[0]});
		$display("test irq done");
	endtask

	// Push button status follows the button through the pin.
	task automatic t_button();
		@(posedge clk);
		button_n <= 1'b0;
		tick(4);
		chk("button low", 8'h01, {6'h0, btn_o, btn_oe});
		@(posedge clk);
		button_n <= 1'b1;
		tick(4);
		chk("button free", 8'h00, {7'h0, btn_oe});
		$display("test button done");
	endtask

	// Clock enable low: a write is not taken and the registers hold.
	task automatic t_freeze();
		@(posedge clk);
		ce <= 1'b0;
		reg_write(VOFS[1], 8'h15);
		@(posedge clk);
		ce <= 1'b1;
		read_chk("frozen write", VOFS[1], 8'h3f);
		$display("test freeze done");
	endtask

	// Cuts a hung run short.
	always @(posedge clk) begin
		cycles <= cycles + 1;
		if (cycles == 5000) begin
			bad_count++;
			stop_test();
		end
	end

	// Main sequence.
	initial begin
		repeat (12) @(posedge clk);
		nrst <= 1'b1;
		t_reset();
		t_fields();
		t_turnon();
		t_irq();
		t_button();
		t_freeze();
		stop_test();
	end
endmodule
